// ==== src/etsr_top.sv ====
// Erase timer and status report sequencer with APB register access.
// Assumes an array engine that starts on pulses and reports done.
`include "etsr_params.svh"
`default_nettype none
module etsr_top #(
    parameter int unsigned WIN_CYC = `ETSR_WIN_CYC,
    parameter int unsigned PROG_LIM = `ETSR_PROG_LIM,
    parameter int unsigned ERASE_LIM = `ETSR_ERASE_LIM
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] array_data_i,
    input wire logic array_done_i,
    output logic erase_start_o,
    output logic prog_start_o,
    output logic erase_hold_o,
    output logic [7:0] erase_sectors_o,
    output logic ready_busy_out_o,
    output logic ready_busy_oe_o,
    output logic irq_o
);
    import etsr_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    etsr_state_t st;
    etsr_op_t op;
    logic [7:0] pend;
    logic [2:0] raddr;
    logic [2:0] sec;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [23:0] pcnt;
    logic [23:0] ecnt;
    logic [15:0] tmr_cnt;
    logic [7:0] stat_w;
    logic tmr_exp, busy_w, tog, stog, dbit, fail_erase;
    logic setup, acc, mapped, wr, rd, cmd_we, stat_rd, irq_rd;
    logic se_acc, ce_acc, prog_acc, susp_acc, ev_start, ev_done, lim_hit;
    logic sec_hit, op_busy, erase_view;

    // Bus decode; the slave answers in the first access cycle
    assign setup = psel_i & ~penable_i;
    assign acc = psel_i & penable_i;
    assign mapped = hit(paddr_i, `ETSR_OFF_CMD) | hit(paddr_i, `ETSR_OFF_RADDR)
                  | hit(paddr_i, `ETSR_OFF_STAT) | hit(paddr_i, `ETSR_OFF_PEND)
                  | hit(paddr_i, `ETSR_OFF_IRQ) | hit(paddr_i, `ETSR_OFF_MASK);
    assign pready_o = 1'b1;
    assign pslverr_o = acc & ~mapped;
    assign wr = acc & pwrite_i & ce_i;
    assign rd = acc & ~pwrite_i & ce_i;
    assign cmd_we = wr & hit(paddr_i, `ETSR_OFF_CMD);
    assign stat_rd = rd & hit(paddr_i, `ETSR_OFF_STAT);
    assign irq_rd = rd & hit(paddr_i, `ETSR_OFF_IRQ);
    assign op = etsr_op_t'(pwdata_i[2:0]);
    assign sec = pwdata_i[`ETSR_CMD_SEC_LSB +: 3];

    // Command acceptance per state
    assign se_acc = cmd_we && op == OP_SERASE
                 && (st == ST_IDLE || st == ST_WIN);
    assign ce_acc = cmd_we && op == OP_CERASE && st == ST_IDLE;
    assign prog_acc = cmd_we && op == OP_PROG
                   && (st == ST_IDLE || st == ST_SUSP);
    assign susp_acc = cmd_we && op == OP_SUSP && st == ST_ERASE;
    assign op_busy = st == ST_ERASE || st == ST_PROG || st == ST_SPROG;
    assign lim_hit = !array_done_i
        && ((st == ST_ERASE && ecnt == 24'(ERASE_LIM - 1))
         || ((st == ST_PROG || st == ST_SPROG)
          && pcnt == 24'(PROG_LIM - 1)));
    assign ev_start = (st == ST_WIN && tmr_exp && !se_acc) || ce_acc;
    assign ev_done = op_busy && array_done_i;
    assign sec_hit = pend[raddr];
    assign erase_view = st == ST_WIN || st == ST_ERASE || st == ST_SUSP
                     || (st == ST_FAIL && fail_erase);

    etsr_timer #(
        .CYC(WIN_CYC)
    ) u_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .restart_i(se_acc),
        .run_i(st == ST_WIN),
        .exp_o(tmr_exp),
        .cnt_o(tmr_cnt)
    );

    etsr_status_mux u_mux (
        .st_i(st),
        .tog_i(tog),
        .stog_i(stog),
        .hit_i(sec_hit),
        .dbit_i(dbit),
        .fail_erase_i(fail_erase),
        .array_i(array_data_i),
        .stat_o(stat_w),
        .busy_o(busy_w)
    );

    // Sequencer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= ST_IDLE;
        end else if (ce_i) begin
            case (st)
                ST_IDLE: begin
                    if (se_acc) begin
                        st <= ST_WIN;
                    end else if (ce_acc) begin
                        st <= ST_ERASE;
                    end else if (prog_acc) begin
                        st <= ST_PROG;
                    end
                end
                ST_WIN: begin
                    if (tmr_exp && !se_acc) begin
                        st <= ST_ERASE;
                    end
                end
                ST_ERASE: begin
                    if (lim_hit) begin
                        st <= ST_FAIL;
                    end else if (array_done_i) begin
                        st <= ST_IDLE;
                    end else if (susp_acc) begin
                        st <= ST_SUSP;
                    end
                end
                ST_SUSP: begin
                    if (prog_acc) begin
                        st <= ST_SPROG;
                    end else if (cmd_we && op == OP_RESUME) begin
                        st <= ST_ERASE;
                    end
                end
                ST_SPROG: begin
                    if (lim_hit) begin
                        st <= ST_FAIL;
                    end else if (array_done_i) begin
                        st <= ST_SUSP;
                    end
                end
                ST_PROG: begin
                    if (lim_hit) begin
                        st <= ST_FAIL;
                    end else if (array_done_i) begin
                        st <= ST_IDLE;
                    end
                end
                ST_FAIL: begin
                    if (cmd_we && op == OP_RESET) begin
                        st <= ST_IDLE;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // Pending sector selection, one flip-flop per sector
    for (genvar i = 0; i < `ETSR_NSEC; i++) begin : g_pend
        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                pend[i] <= 1'b0;
            end else if (ce_i) begin
                if (ce_acc) begin
                    pend[i] <= 1'b1;
                end else if (se_acc && st == ST_IDLE) begin
                    pend[i] <= (sec == 3'(i));
                end else if (se_acc && sec == 3'(i)) begin
                    pend[i] <= 1'b1;
                end else if ((st == ST_ERASE && ev_done && !lim_hit)
                          || (st == ST_FAIL && cmd_we && op == OP_RESET)) begin
                    pend[i] <= 1'b0;
                end
            end
        end
    end
    assign erase_sectors_o = pend;

    // Internal time limit counters; erase count holds while suspended
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pcnt <= 24'h000000;
            ecnt <= 24'h000000;
        end else if (ce_i) begin
            if (prog_acc) begin
                pcnt <= 24'h000000;
            end else if (st == ST_PROG || st == ST_SPROG) begin
                pcnt <= pcnt + 24'h000001;
            end
            if (ev_start) begin
                ecnt <= 24'h000000;
            end else if (st == ST_ERASE) begin
                ecnt <= ecnt + 24'h000001;
            end
        end
    end

    // Program data bit and failed operation kind
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dbit <= 1'b0;
            fail_erase <= 1'b0;
        end else if (ce_i) begin
            if (prog_acc) begin
                dbit <= pwdata_i[`ETSR_CMD_DAT_BIT];
            end
            if (lim_hit) begin
                fail_erase <= (st == ST_ERASE);
            end
        end
    end

    // Toggle bits advance after a status read: main toggle while busy, sector toggle in a pending sector during erase
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tog <= 1'b0;
            stog <= 1'b0;
        end else if (stat_rd) begin
            if (busy_w) begin
                tog <= ~tog;
            end
            if (erase_view && sec_hit) begin
                stog <= ~stog;
            end
        end
    end

    // Array control and open-drain busy pin
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            erase_start_o <= 1'b0;
            prog_start_o <= 1'b0;
            erase_hold_o <= 1'b0;
            ready_busy_oe_o <= 1'b0;
        end else if (ce_i) begin
            erase_start_o <= ev_start;
            prog_start_o <= prog_acc;
            ready_busy_oe_o <= busy_w;
            if (susp_acc) begin
                erase_hold_o <= 1'b1;
            end else if (st != ST_SUSP && st != ST_SPROG) begin
                erase_hold_o <= 1'b0;
            end
        end
    end
    assign ready_busy_out_o = 1'b0;

    // Registers; read data is captured in the setup cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            raddr <= `ETSR_RADDR_RST;
            irq_mask <= `ETSR_MASK_RST;
            prdata_o <= 32'h00000000;
        end else if (ce_i) begin
            if (wr && hit(paddr_i, `ETSR_OFF_RADDR)) begin
                raddr <= pwdata_i[2:0];
            end
            if (wr && hit(paddr_i, `ETSR_OFF_MASK)) begin
                irq_mask <= pwdata_i[2:0];
            end
            if (setup) begin
                prdata_o <= 32'h00000000;
                if (hit(paddr_i, `ETSR_OFF_RADDR)) begin
                    prdata_o[2:0] <= raddr;
                end
                if (hit(paddr_i, `ETSR_OFF_STAT)) begin
                    prdata_o[7:0] <= stat_w;
                    prdata_o[`ETSR_ST_RDY] <= ~busy_w;
                end
                if (hit(paddr_i, `ETSR_OFF_PEND)) begin
                    prdata_o[10:0] <= {st, pend};
                end
                if (hit(paddr_i, `ETSR_OFF_IRQ)) begin
                    prdata_o[2:0] <= irq_st;
                end
                if (hit(paddr_i, `ETSR_OFF_MASK)) begin
                    prdata_o[2:0] <= irq_mask;
                end
            end
        end
    end

    // Sticky events; a read clears only what it returned, a new set wins
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_st <= 3'h0;
        end else if (ce_i) begin
            irq_st <= (irq_st & ~(irq_rd ? prdata_o[2:0] : 3'h0))
                    | {lim_hit, ev_done && !lim_hit, ev_start};
        end
    end
    assign irq_o = |(irq_st & irq_mask);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_win_flag;
        st == ST_WIN |-> !stat_w[`ETSR_ST_TMR] && busy_w;
    endproperty
    a_win_flag: assert property (p_win_flag)
        else $error("timer flag high inside window");
    property p_win_end;
        ce_i && st == ST_WIN && tmr_exp && !se_acc
        |=> st == ST_ERASE && stat_w[`ETSR_ST_TMR];
    endproperty
    a_win_end: assert property (p_win_end)
        else $error("window expiry did not start erase");
    property p_chip;
        ce_i && ce_acc |=> st == ST_ERASE && erase_start_o;
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip erase went through window");
    property p_restart;
        ce_i && st == ST_WIN && se_acc |=> tmr_cnt == 16'h0000 && st == ST_WIN;
    endproperty
    a_restart: assert property (p_restart)
        else $error("extra sector erase did not restart window");
    property p_ignore;
        ce_i && st == ST_ERASE && cmd_we && op != OP_SUSP && !array_done_i
        |=> pend == $past(pend) && st != ST_SUSP;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("command taken during erase");
    property p_add;
        ce_i && se_acc |=> pend[$past(sec)];
    endproperty
    a_add: assert property (p_add)
        else $error("sector not added");
    property p_prog;
        st == ST_PROG |-> stat_w[`ETSR_ST_POLL] == ~dbit && busy_w
            && !stat_w[`ETSR_ST_FAIL];
    endproperty
    a_prog: assert property (p_prog)
        else $error("program status wrong");
    property p_susp;
        st == ST_SUSP |-> !busy_w && (sec_hit
            ? stat_w[`ETSR_ST_POLL] && !stat_w[`ETSR_ST_FAIL]
            : stat_w == array_data_i);
    endproperty
    a_susp: assert property (p_susp)
        else $error("suspend status wrong");
    property p_fail;
        ce_i && lim_hit |=> st == ST_FAIL && stat_w[`ETSR_ST_FAIL];
    endproperty
    a_fail: assert property (p_fail)
        else $error("limit overrun not flagged");
    property p_tog;
        stat_rd && busy_w |=> tog != $past(tog);
    endproperty
    a_tog: assert property (p_tog)
        else $error("toggle bit did not flip");

    c_restart: cover property (st == ST_WIN && se_acc ##[1:20] ev_start);
    c_chip: cover property (ce_acc);
    c_sprog: cover property (st == ST_SPROG ##[1:50] st == ST_SUSP);
    c_fail: cover property (lim_hit);
endmodule : etsr_top
`default_nettype wire

// ==== common/etsr_params.svh ====
// Constants of the erase timer and status report block.
// Assumes a 100 MHz core clock and a 32-bit APB slave port.
// Operation
// - After a sector erase sequence the erase timer flag reads 0 during the acceptance window and 1 once the window has expired.
// - A chip erase starts at once and never opens the acceptance window.
// - Each sector erase taken during the window restarts the whole window.
// - Once the flag is 1 the erase runs and every command except erase suspend is ignored until it ends.
// - While the flag is 0 further sector erase commands are taken and their sectors added to the pending set.
// - Program shows the inverted data bit, a toggling main toggle, fail 0 and busy; erase shows poll 0, both toggles and flag 1.
// - In erase suspend a read in a suspended sector shows poll 1, steady main toggle, fail 0, toggling sector toggle, ready.
// - In erase suspend a read outside the suspended sectors shows array data and ready.
// - The fail bit goes to 1 when a program or erase overruns its internal time limit.
// - While an operation runs each status read flips the main toggle bit, and it stops when the operation ends.
`ifndef ETSR_PARAMS_SVH
`define ETSR_PARAMS_SVH
`define ETSR_CLK_NS 10
`define ETSR_WIN_US 50
`define ETSR_WIN_CYC ((`ETSR_WIN_US * 1000 + `ETSR_CLK_NS - 1) / `ETSR_CLK_NS)
`define ETSR_PROG_LIM 4000
`define ETSR_ERASE_LIM 500000
`define ETSR_NSEC 8
`define ETSR_OFF_CMD 8'h00
`define ETSR_OFF_RADDR 8'h04
`define ETSR_OFF_STAT 8'h08
`define ETSR_OFF_PEND 8'h0C
`define ETSR_OFF_IRQ 8'h10
`define ETSR_OFF_MASK 8'h14
`define ETSR_CMD_SEC_LSB 8
`define ETSR_CMD_DAT_BIT 16
`define ETSR_ST_POLL 7
`define ETSR_ST_TOG 6
`define ETSR_ST_FAIL 5
`define ETSR_ST_TMR 3
`define ETSR_ST_STOG 2
`define ETSR_ST_RDY 8
`define ETSR_IRQ_START 0
`define ETSR_IRQ_DONE 1
`define ETSR_IRQ_FAIL 2
`define ETSR_MASK_RST 3'h0
`define ETSR_RADDR_RST 3'h0
`endif

// ==== common/etsr_pkg.sv ====
// Types of the erase timer and status report block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package etsr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WIN = 3'h1,
        ST_ERASE = 3'h3,
        ST_SUSP = 3'h2,
        ST_SPROG = 3'h6,
        ST_PROG = 3'h4,
        ST_FAIL = 3'h5
    } etsr_state_t;
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_SERASE = 3'h1,
        OP_CERASE = 3'h2,
        OP_PROG = 3'h3,
        OP_SUSP = 3'h4,
        OP_RESUME = 3'h5,
        OP_RESET = 3'h6
    } etsr_op_t;
endpackage : etsr_pkg
`default_nettype wire

// ==== src/etsr_timer.sv ====
// Acceptance window timer for sector erase.
// Assumes restart and run come from the sequencer in the same clock domain.
`include "etsr_params.svh"
`default_nettype none
module etsr_timer #(
    parameter int unsigned CYC = `ETSR_WIN_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic restart_i,
    input wire logic run_i,
    output logic exp_o,
    output logic [15:0] cnt_o
);
    assign exp_o = (cnt_o == 16'(CYC - 1));

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_o <= 16'h0000;
        end else if (ce_i) begin
            if (restart_i) begin
                cnt_o <= 16'h0000;
            end else if (run_i && !exp_o) begin
                cnt_o <= cnt_o + 16'h0001;
            end
        end
    end
endmodule : etsr_timer
`default_nettype wire

// ==== src/etsr_status_mux.sv ====
// Builds the status byte and busy level seen by a status read.
// Assumes toggle bits and sector hit are prepared by the sequencer.
`include "etsr_params.svh"
`default_nettype none
module etsr_status_mux (
    input wire etsr_pkg::etsr_state_t st_i,
    input wire logic tog_i,
    input wire logic stog_i,
    input wire logic hit_i,
    input wire logic dbit_i,
    input wire logic fail_erase_i,
    input wire logic [7:0] array_i,
    output logic [7:0] stat_o,
    output logic busy_o
);
    import etsr_pkg::*;

    function automatic logic [7:0] pack(input logic p, input logic t,
                                        input logic f, input logic d3,
                                        input logic d2);
        logic [7:0] s;
        s = 8'h00;
        s[`ETSR_ST_POLL] = p;
        s[`ETSR_ST_TOG] = t;
        s[`ETSR_ST_FAIL] = f;
        s[`ETSR_ST_TMR] = d3;
        s[`ETSR_ST_STOG] = d2;
        return s;
    endfunction : pack

    logic es;
    assign es = hit_i & stog_i;

    always_comb begin
        stat_o = array_i;
        busy_o = 1'b1;
        case (st_i)
            ST_IDLE: busy_o = 1'b0;
            ST_PROG, ST_SPROG: stat_o = pack(~dbit_i, tog_i, 1'b0, 1'b0,
                                             1'b0);
            ST_WIN: stat_o = pack(1'b0, tog_i, 1'b0, 1'b0, es);
            ST_ERASE: stat_o = pack(1'b0, tog_i, 1'b0, 1'b1, es);
            ST_SUSP: begin
                busy_o = 1'b0;
                if (hit_i) begin
                    stat_o = pack(1'b1, tog_i, 1'b0, 1'b0, stog_i);
                end
            end
            ST_FAIL: begin
                if (fail_erase_i) begin
                    stat_o = pack(1'b0, tog_i, 1'b1, 1'b1, es);
                end else begin
                    stat_o = pack(~dbit_i, tog_i, 1'b1, 1'b0, 1'b0);
                end
            end
            default: busy_o = 1'b0;
        endcase
    end
endmodule : etsr_status_mux
`default_nettype wire

// ==== dv/etsr_array_model.sv ====
// Array engine stand-in: answers erase and program after a set delay.
// Assumes one-cycle start pulses; the count pauses while erase is held.
`default_nettype none
module etsr_array_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic erase_i,
    input wire logic prog_i,
    input wire logic hold_i,
    input wire logic slow_i,
    output logic done_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt, pc;
    assign data_o = 8'h5A;
    // Program has its own count so a suspended erase keeps its progress
    always @(posedge core_clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
            pc <= 0;
        end else if (prog_i) begin
            pc <= slow_i ? 200 : 12;
        end else if (erase_i) begin
            cnt <= slow_i ? 200 : 40;
        end else if (pc > 0) begin
            done_o <= (pc == 1);
            pc <= pc - 1;
        end else if (cnt > 0 && !hold_i) begin
            done_o <= (cnt == 1);
            cnt <= cnt - 1;
        end
    end
endmodule : etsr_array_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench of the erase timer and status report block.
// Assumes the array model, short window and limits set below.
`include "etsr_params.svh"
`default_nettype none
module tb_top;
    import etsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 20;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic [31:0] prdata_o, q, s1, s2;
    logic pready_o, pslverr_o, erase_start_o, prog_start_o, erase_hold_o;
    logic [7:0] erase_sectors_o, array_data_i;
    logic array_done_i, ready_busy_out_o, ready_busy_oe_o, irq_o, e;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;

    initial forever #5 core_clk_i = ~core_clk_i;

    etsr_top #(.WIN_CYC(WIN), .PROG_LIM(30), .ERASE_LIM(60)) dut_u (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .array_data_i(array_data_i), .array_done_i(array_done_i),
        .erase_start_o(erase_start_o), .prog_start_o(prog_start_o),
        .erase_hold_o(erase_hold_o), .erase_sectors_o(erase_sectors_o),
        .ready_busy_out_o(ready_busy_out_o),
        .ready_busy_oe_o(ready_busy_oe_o), .irq_o(irq_o));

    etsr_array_model arr_u (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .erase_i(erase_start_o),
        .prog_i(prog_start_o), .hold_i(erase_hold_o), .slow_i(slow),
        .done_o(array_done_i), .data_o(array_data_i));

    task automatic chk(input logic [31:0] g, input logic [31:0] x,
                       input string m);
        comparisons++;
        if (g !== x) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    function automatic logic [31:0] cmd(input etsr_op_t o,
                                        input logic [2:0] s, input logic d);
        return {15'h0000, d, 5'h00, s, 5'h00, o};
    endfunction : cmd

    task automatic rd2;
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        s1 = q;
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        s2 = q;
    endtask : rd2

    task automatic wait_start;
        n = 0;
        while (erase_start_o !== 1'b1 && n < 100) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask : wait_start

    task automatic wait_idle;
        n = 0;
        apb(1'b0, `ETSR_OFF_PEND, 32'h0);
        while (q[10:8] !== 3'h0 && n < 60) begin
            apb(1'b0, `ETSR_OFF_PEND, 32'h0);
            n++;
        end
        chk(q[10:8], 3'h0, "back to idle");
    endtask : wait_idle

    task automatic t_reset;
        apb(1'b0, `ETSR_OFF_MASK, 32'h0);
        chk(q, 32'h0, "mask reset");
        apb(1'b0, `ETSR_OFF_RADDR, 32'h0);
        chk(q, 32'h0, "raddr reset");
        ce <= 1'b0;
        apb(1'b1, `ETSR_OFF_MASK, 32'h5);
        ce <= 1'b1;
        apb(1'b0, `ETSR_OFF_MASK, 32'h0);
        chk(q, 32'h0, "write frozen");
        chk(ready_busy_out_o, 1'b0, "open drain low");
        apb(1'b0, 8'h20, 32'h0);
        chk(e, 1'b1, "unmapped error");
        $display("test reset done");
    endtask : t_reset

    task automatic t_window;
        apb(1'b1, `ETSR_OFF_RADDR, 32'h1);
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_SERASE, 3'h1, 1'b0));
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        chk({q[8], q[7], q[3]}, 3'b000, "window status");
        repeat (6) @(posedge core_clk_i);
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        chk(q[3], 1'b0, "flag before extra");
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_SERASE, 3'h2, 1'b0));
        wait_start;
        chk(n >= WIN - 2 && n <= WIN + 3, 1'b1, "window restart");
        chk(erase_sectors_o, 8'h06, "pending set");
        rd2;
        chk({s1[8], s1[7], s1[3]}, 3'b001, "erase status");
        chk(s1[6] ^ s2[6], 1'b1, "main toggle");
        chk(s1[2] ^ s2[2], 1'b1, "sector toggle");
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_SERASE, 3'h4, 1'b0));
        apb(1'b0, `ETSR_OFF_PEND, 32'h0);
        chk(q[10:0], {3'h3, 8'h06}, "command ignored");
        $display("test window done");
    endtask : t_window

    task automatic t_suspend;
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_SUSP, 3'h0, 1'b0));
        rd2;
        chk(erase_hold_o, 1'b1, "held");
        chk({s1[8], s1[7], s1[5]}, 3'b110, "suspended sector");
        chk(s1[6] ^ s2[6], 1'b0, "main toggle still");
        chk(s1[2] ^ s2[2], 1'b1, "sector toggle");
        chk(ready_busy_oe_o, 1'b0, "ready pin");
        apb(1'b1, `ETSR_OFF_RADDR, 32'h6);
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        chk(q[8:0], {1'b1, 8'h5A}, "other sector data");
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_PROG, 3'h0, 1'b1));
        rd2;
        chk({s1[8], s1[7], s1[5]}, 3'b000, "suspend program");
        chk(s1[6] ^ s2[6], 1'b1, "suspend program toggle");
        repeat (20) @(posedge core_clk_i);
        apb(1'b0, `ETSR_OFF_PEND, 32'h0);
        chk(q[10:8], 3'h2, "back to suspend");
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_RESUME, 3'h0, 1'b0));
        wait_idle;
        $display("test suspend done");
    endtask : t_suspend

    task automatic t_chip;
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_CERASE, 3'h0, 1'b0));
        wait_start;
        chk(n < 3, 1'b1, "chip erase at once");
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        chk(q[3], 1'b1, "no window");
        chk(erase_sectors_o, 8'hFF, "all sectors");
        wait_idle;
        $display("test chip done");
    endtask : t_chip

    task automatic t_prog;
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_PROG, 3'h0, 1'b1));
        @(posedge core_clk_i);
        chk(prog_start_o, 1'b1, "program start");
        rd2;
        chk({s1[8], s1[7], s1[5]}, 3'b000, "program status");
        chk(ready_busy_oe_o, 1'b1, "busy pin");
        chk(s1[6] ^ s2[6], 1'b1, "main toggle");
        wait_idle;
        rd2;
        chk(s1[6] ^ s2[6], 1'b0, "toggle stopped");
        $display("test program done");
    endtask : t_prog

    task automatic t_fail;
        apb(1'b1, `ETSR_OFF_MASK, 32'h7);
        apb(1'b0, `ETSR_OFF_IRQ, 32'h0);
        slow <= 1'b1;
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_PROG, 3'h0, 1'b0));
        n = 0;
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        while (q[5] !== 1'b1 && n < 40) begin
            apb(1'b0, `ETSR_OFF_STAT, 32'h0);
            n++;
        end
        chk(q[5], 1'b1, "limit fail");
        chk(irq_o, 1'b1, "irq raised");
        apb(1'b0, `ETSR_OFF_IRQ, 32'h0);
        chk(q[2], 1'b1, "fail event");
        apb(1'b0, `ETSR_OFF_IRQ, 32'h0);
        chk(q[2:0], 3'h0, "irq cleared");
        chk(irq_o, 1'b0, "irq low");
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_RESET, 3'h0, 1'b0));
        wait_idle;
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_CERASE, 3'h0, 1'b0));
        repeat (70) @(posedge core_clk_i);
        apb(1'b0, `ETSR_OFF_STAT, 32'h0);
        chk({q[5], q[3]}, 2'b11, "erase limit fail");
        slow <= 1'b0;
        apb(1'b1, `ETSR_OFF_CMD, cmd(OP_RESET, 3'h0, 1'b0));
        wait_idle;
        $display("test fail done");
    endtask : t_fail

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_window;
        t_suspend;
        t_chip;
        t_prog;
        t_fail;
        results;
    end

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results;
        end
    end
endmodule : tb_top
`default_nettype wire
